/* File: rtl/prmc_unit.sv */
// execution datapath: rotate left n, table select read/write, signed compares
`timescale 1ns/100ps
`include "prmc_defines.svh"
// Behaviour
// (RULE1) enabled rotate left by 1-16, store destination
// (RULE2) rotate output equals result msb
// (RULE3) carry flag takes the pushed out bit
// (RULE4) table read copies start+pointer entry to destination
// (RULE5) table write copies source into start+pointer entry
// (RULE6) table size 1-64, pointer 0-63
// (RULE7) pointer over size: no transfer, output high
// (RULE8) normal table transfer or disabled: output low
// (RULE9) program keeps whole table inside memory
// (RULE10) greater-than compare drives output high
// (RULE11) greater-or-equal compare drives output high
// (RULE12) compares treat operands as signed
// (RULE13) 16-bit two's complement words, circular rotation
// (RULE14) disabled: no register or carry change, output low
module prmc_unit import prmc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // instruction issue from the scan sequencer
    input wire logic issue,
    input wire prmc_instr_s instr,
    // operand memory access port
    input wire logic mem_wr,
    input wire prmc_addr_t mem_addr,
    input wire prmc_word_t mem_wdata,
    output prmc_word_t mem_rdata_reg,
    // instruction results
    output logic done_reg,
    output logic result_reg,
    output logic carry_flag_reg
);
    // operand memory, no reset: contents belong to the program
    prmc_word_t regs_mem [`PRMC_DEPTH];

    prmc_word_t src_a;
    prmc_word_t opb;
    prmc_word_t ptr;
    prmc_word_t rot_word;
    prmc_addr_t tbl_addr;
    logic rot_carry;
    logic exec;
    logic shift_ok;
    logic ptr_over;
    logic cmp_gt;
    logic cmp_ge;

    logic wr_en;
    prmc_addr_t wr_addr;
    prmc_word_t wr_data;
    logic done_next;
    logic result_next;
    logic carry_flag_next;
    prmc_word_t mem_rdata_next;

    prmc_rotate u_rotate (
        .word_in(src_a),
        .count(instr.shift),
        .word_out(rot_word),
        .carry_out(rot_carry)
    );

    always_comb begin
        src_a = regs_mem[instr.a_addr];
        ptr = regs_mem[instr.b_addr];
        opb = instr.b_const_sel ? instr.b_const : regs_mem[instr.b_addr];
        exec = issue && instr.rung_en;
        shift_ok = (instr.shift >= `PRMC_SHIFT_MIN) && (instr.shift <= `PRMC_SHIFT_MAX); // RULE1
        // a size outside 1-64 is treated like a pointer over
        ptr_over = (instr.size < `PRMC_TBL_MIN) || (instr.size > `PRMC_TBL_MAX)
                   || (ptr >= {9'h000, instr.size}); // RULE6 RULE7
        cmp_gt = $signed(src_a) > $signed(opb); // RULE12
        cmp_ge = $signed(src_a) >= $signed(opb); // RULE12
        tbl_addr = 8'(instr.a_addr + ptr[`PRMC_AW-1:0]);
        if (instr.op == PRMC_OP_TABLE_SELECT_WRITE) begin
            // table wraps at the top of memory; placement is the program's job
            tbl_addr = 8'(instr.c_addr + ptr[`PRMC_AW-1:0]); // RULE9
        end
    end

    always_comb begin
        wr_en = 1'h0;
        wr_addr = instr.c_addr;
        wr_data = src_a;
        done_next = issue;
        result_next = 1'h0; // RULE14 RULE8
        carry_flag_next = carry_flag_reg; // RULE14
        mem_rdata_next = regs_mem[mem_addr];
        if (exec) begin
            unique case (instr.op)
                PRMC_OP_ROTATE_LEFT_N: begin
                    if (shift_ok) begin
                        wr_en = 1'h1; // RULE1 RULE13
                        wr_data = rot_word;
                        result_next = rot_word[`PRMC_W-1]; // RULE2
                        carry_flag_next = rot_carry; // RULE3
                    end
                end
                PRMC_OP_TABLE_SELECT_READ: begin
                    wr_en = !ptr_over; // RULE4 RULE7
                    wr_addr = instr.c_addr;
                    wr_data = regs_mem[tbl_addr];
                    result_next = ptr_over; // RULE7 RULE8
                end
                PRMC_OP_TABLE_SELECT_WRITE: begin
                    wr_en = !ptr_over; // RULE5 RULE7
                    wr_addr = tbl_addr;
                    wr_data = src_a;
                    result_next = ptr_over; // RULE7 RULE8
                end
                PRMC_OP_GT: result_next = cmp_gt; // RULE10
                PRMC_OP_GE: result_next = cmp_ge; // RULE11
                default: result_next = 1'h0;
            endcase
        end else if (!issue && mem_wr) begin
            // the port only writes while no instruction is issued
            wr_en = 1'h1;
            wr_addr = mem_addr;
            wr_data = mem_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            regs_mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= 1'h0;
            result_reg <= 1'h0;
            carry_flag_reg <= `PRMC_CARRY_RST;
            mem_rdata_reg <= `PRMC_WORD_RST;
        end else begin
            done_reg <= done_next;
            result_reg <= result_next;
            carry_flag_reg <= carry_flag_next;
            mem_rdata_reg <= mem_rdata_next;
        end
    end

    // reference rotation for checking the rotator
    logic [2*`PRMC_W-1:0] rot_ref;
    assign rot_ref = {src_a, src_a} << instr.shift;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic rot_exec;
    logic tbl_exec;
    assign rot_exec = exec && instr.op == PRMC_OP_ROTATE_LEFT_N && shift_ok;
    assign tbl_exec = exec && (instr.op == PRMC_OP_TABLE_SELECT_READ
                               || instr.op == PRMC_OP_TABLE_SELECT_WRITE);

    // enable gating
    a_idle_quiet: assert property (!issue |=> !done_reg && !result_reg) // RULE14
        else $error("outputs active without an issue");
    a_disabled_low: assert property (issue && !instr.rung_en // RULE14
                                     |=> done_reg && !result_reg && $stable(carry_flag_reg))
        else $error("disabled instruction changed output or carry");
    a_disabled_nowrite: assert property (issue && !instr.rung_en |-> !wr_en) // RULE14
        else $error("disabled instruction wrote memory");
    a_carry_hold: assert property (!rot_exec |=> $stable(carry_flag_reg)) // RULE3 RULE14
        else $error("carry flag changed without an executed rotation");

    // rotation
    a_rot_wrap: assert property (rot_exec // RULE1 RULE13
                                 |-> wr_en && wr_data == rot_ref[2*`PRMC_W-1:`PRMC_W]
                                 && wr_addr == instr.c_addr)
        else $error("rotate result or destination wrong");
    a_rot_out_msb: assert property (rot_exec // RULE2
                                    |=> result_reg == $past(rot_ref[2*`PRMC_W-1]))
        else $error("rotate output does not follow msb");
    a_rot_carry: assert property (rot_exec // RULE3
                                  |=> carry_flag_reg == $past(rot_ref[`PRMC_W]))
        else $error("carry flag does not hold pushed out bit");
    a_rot_full_turn: assert property (rot_exec && instr.shift == `PRMC_SHIFT_MAX // RULE13
                                      |-> wr_data == src_a)
        else $error("a full turn of sixteen did not give the word back");
    // a count outside 1-16 must not have its rotator result stored, since the rotator would wrap it silently
    a_shift_range: assert property (exec && instr.op == PRMC_OP_ROTATE_LEFT_N // RULE1
                                    && !shift_ok |-> !wr_en ##1 !result_reg)
        else $error("out of range shift count was executed");

    // table select
    a_tbl_over_skip: assert property (tbl_exec && ptr >= {9'h000, instr.size} // RULE7
                                      |-> !wr_en ##1 result_reg)
        else $error("pointer over did not skip or raise output");
    a_tbl_size_range: assert property (tbl_exec && (instr.size < `PRMC_TBL_MIN // RULE6 RULE7
                                       || instr.size > `PRMC_TBL_MAX) |-> !wr_en ##1 result_reg)
        else $error("table size outside 1-64 was not refused");
    a_tbl_read_copy: assert property (exec && instr.op == PRMC_OP_TABLE_SELECT_READ // RULE4 RULE8
                                      && !ptr_over |-> wr_en && wr_addr == instr.c_addr
                                      ##1 !result_reg)
        else $error("table read did not copy to destination");
    a_tbl_read_data: assert property (exec && instr.op == PRMC_OP_TABLE_SELECT_READ // RULE4
                                      && !ptr_over
                                      |-> wr_data == regs_mem[8'(instr.a_addr + ptr[7:0])])
        else $error("table read copied the wrong entry");
    a_tbl_write_dest: assert property (exec && instr.op == PRMC_OP_TABLE_SELECT_WRITE // RULE5
                                       && !ptr_over |-> wr_data == src_a
                                       && wr_addr == 8'(instr.c_addr + ptr[7:0]))
        else $error("table write went to wrong entry");
    a_tbl_write_low: assert property (exec && instr.op == PRMC_OP_TABLE_SELECT_WRITE // RULE8
                                      && !ptr_over |=> !result_reg)
        else $error("normal table write left the output high");

    // signed compares
    a_cmp_gt: assert property (exec && instr.op == PRMC_OP_GT // RULE10 RULE12
                               |=> result_reg == ($signed($past(src_a)) > $signed($past(opb))))
        else $error("greater-than result wrong");
    a_cmp_ge: assert property (exec && instr.op == PRMC_OP_GE // RULE11 RULE12
                               |=> result_reg == !($signed($past(src_a)) < $signed($past(opb))))
        else $error("greater-or-equal result wrong");

    c_rot_full: cover property (rot_exec && instr.shift == `PRMC_SHIFT_MAX);
    c_tbl_over: cover property (tbl_exec ##1 result_reg);
    c_tbl_write_ok: cover property (exec && instr.op == PRMC_OP_TABLE_SELECT_WRITE && !ptr_over);
    c_cmp_neg: cover property (exec && instr.op == PRMC_OP_GE && src_a[`PRMC_W-1] && !cmp_ge);
    c_back_to_back: cover property (exec ##1 exec);
endmodule : prmc_unit

/* File: rtl/prmc_defines.svh */
// widths, ranges and reset values of the rotate, table select and compare unit
`ifndef PRMC_DEFINES_SVH
`define PRMC_DEFINES_SVH
`define PRMC_W 16
`define PRMC_AW 8
`define PRMC_DEPTH 256
`define PRMC_CNT_W 5
`define PRMC_SIZE_W 7
`define PRMC_SHIFT_MIN 5'h01
`define PRMC_SHIFT_MAX 5'h10
`define PRMC_TBL_MIN 7'h01
`define PRMC_TBL_MAX 7'h40
`define PRMC_CARRY_RST 1'h0
`define PRMC_WORD_RST 16'h0000
`endif

/* File: rtl/prmc_pkg.sv */
// types shared by the rotate, table select and compare unit
`include "prmc_defines.svh"
package prmc_pkg;
    typedef logic [`PRMC_W-1:0] prmc_word_t;
    typedef logic [`PRMC_AW-1:0] prmc_addr_t;

    typedef enum logic [2:0] {
        PRMC_OP_ROTATE_LEFT_N,
        PRMC_OP_TABLE_SELECT_READ,
        PRMC_OP_TABLE_SELECT_WRITE,
        PRMC_OP_GT,
        PRMC_OP_GE
    } prmc_op_e;

    typedef struct packed {
        prmc_op_e op;
        logic rung_en;
        prmc_addr_t a_addr;
        prmc_addr_t b_addr;
        prmc_addr_t c_addr;
        logic [`PRMC_SIZE_W-1:0] size;
        logic [`PRMC_CNT_W-1:0] shift;
        logic b_const_sel;
        prmc_word_t b_const;
    } prmc_instr_s;
endpackage : prmc_pkg

/* File: rtl/prmc_rotate.sv */
// circular left rotation of one word by a count of 1 to 16
`timescale 1ns/100ps
`include "prmc_defines.svh"
module prmc_rotate import prmc_pkg::*; (
    // operand
    input wire prmc_word_t word_in,
    input wire logic [`PRMC_CNT_W-1:0] count,
    // result
    output prmc_word_t word_out,
    output logic carry_out
);
    genvar i;
    generate
        for (i = 0; i < `PRMC_W; i = i + 1) begin : g_bit
            // wraps within the word; a count of 16 gives the word back
            wire logic [3:0] src_idx = 4'(5'(i) - count);
            assign word_out[i] = word_in[src_idx];
        end
    endgenerate

    // the last bit pushed out of the msb re-enters at the lsb
    assign carry_out = word_out[0];
endmodule : prmc_rotate

/* File: dv/prmc_seq_model.sv */
// scan sequencer model: loads operand words and issues instructions
`timescale 1ns/100ps
module prmc_seq_model import prmc_pkg::*; (
    // clock and results
    input wire logic clk,
    input wire logic done_reg,
    input wire logic result_reg,
    input wire prmc_word_t mem_rdata_reg,
    // issue and memory port
    output logic issue,
    output prmc_instr_s instr,
    output logic mem_wr,
    output prmc_addr_t mem_addr,
    output prmc_word_t mem_wdata
);
    initial begin
        issue = 1'h0;
        instr = '0;
        mem_wr = 1'h0;
        mem_addr = 8'h00;
        mem_wdata = 16'h0000;
    end
    task automatic put(input prmc_addr_t a, input prmc_word_t d);
        @(posedge clk);
        #1 mem_wr = 1'h1;
        mem_addr = a;
        mem_wdata = d;
        @(posedge clk);
        #1 mem_wr = 1'h0;
        mem_wdata = ~d;
    endtask : put
    task automatic get(input prmc_addr_t a, output prmc_word_t d);
        @(posedge clk);
        #1 mem_addr = a;
        @(posedge clk);
        #1 d = mem_rdata_reg;
    endtask : get
    // result and done stand one cycle, so they are taken just after the answer edge
    task automatic exec(input prmc_instr_s i, output logic dn, output logic res);
        @(posedge clk);
        #1 issue = 1'h1;
        instr = i;
        @(posedge clk);
        #1 issue = 1'h0;
        instr = ~i;
        dn = done_reg;
        res = result_reg;
    endtask : exec
endmodule : prmc_seq_model

/* File: dv/tb_prmc_unit.sv */
// self-checking bench for the rotate, table select and compare unit
`timescale 1ns/100ps
module tb_prmc_unit import prmc_pkg::*;;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic issue, mem_wr, done_reg, result_reg, carry_flag_reg, r, dn;
    prmc_instr_s instr, ins;
    prmc_addr_t mem_addr;
    prmc_word_t mem_wdata, mem_rdata_reg, d, w;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [4:0] shifts [3] = '{5'h01, 5'h03, 5'h10};
    logic [15:0] ptrs [3] = '{16'h0007, 16'h0009, 16'h000A};
    logic [15:0] cmp_a [4] = '{16'h0BB8, 16'hFF9C, 16'h0BB8, 16'hFA24};
    logic [15:0] cmp_b [4] = '{16'h09C4, 16'h09C4, 16'h0BB8, 16'h0000};
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            summarize();
        end
    end
    prmc_unit u_prmc_unit (.clk(clk), .rst_n(rst_n), .issue(issue), .instr(instr),
        .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata_reg(mem_rdata_reg), .done_reg(done_reg), .result_reg(result_reg),
        .carry_flag_reg(carry_flag_reg));
    prmc_seq_model u_prmc_seq_model (.clk(clk), .done_reg(done_reg), .result_reg(result_reg),
        .mem_rdata_reg(mem_rdata_reg), .issue(issue), .instr(instr), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata));
    function automatic prmc_instr_s mk(prmc_op_e op, logic en, prmc_addr_t a, prmc_addr_t b,
        prmc_addr_t c, logic [6:0] sz, logic [4:0] sh);
        return '{op, en, a, b, c, sz, sh, 1'h0, 16'h0000};
    endfunction : mk
    function automatic prmc_word_t rol(prmc_word_t v, logic [4:0] n);
        logic [31:0] t;
        t = {v, v} << n;
        return t[31:16];
    endfunction : rol
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic run(input prmc_instr_s i);
        u_prmc_seq_model.exec(i, dn, r);
        chk("done", 16'(dn), 16'h0001);
    endtask : run
    task automatic t_rotate;
        u_prmc_seq_model.put(8'h01, 16'hB2C5);
        foreach (shifts[k]) begin
            w = rol(16'hB2C5, shifts[k]);
            run(mk(PRMC_OP_ROTATE_LEFT_N, 1'h1, 8'h01, 8'h00, 8'h02, 7'h00, shifts[k]));
            chk("rot_out", 16'(r), 16'(w[15]));
            chk("carry", 16'(carry_flag_reg), 16'(w[0]));
            u_prmc_seq_model.get(8'h02, d);
            chk("rot_dst", d, w);
        end
        // disabled rung: would give 0004 and clear the carry if it ran
        u_prmc_seq_model.put(8'h01, 16'h0002);
        run(mk(PRMC_OP_ROTATE_LEFT_N, 1'h0, 8'h01, 8'h00, 8'h02, 7'h00, 5'h01));
        chk("off_out", 16'(r), 16'h0000);
        chk("off_carry", 16'(carry_flag_reg), 16'h0001);
        u_prmc_seq_model.get(8'h02, d);
        chk("off_dst", d, 16'hB2C5);
        // a count of 17 is refused: would give 0004 and clear the carry if it ran
        run(mk(PRMC_OP_ROTATE_LEFT_N, 1'h1, 8'h01, 8'h00, 8'h02, 7'h00, 5'h11));
        chk("big_out", 16'(r), 16'h0000);
        chk("big_carry", 16'(carry_flag_reg), 16'h0001);
        u_prmc_seq_model.get(8'h02, d);
        chk("big_dst", d, 16'hB2C5);
        $display("test rotate done");
    endtask : t_rotate
    task automatic t_table;
        // ten-entry table at 16..25 sits well inside memory
        for (int k = 0; k < 11; k++) u_prmc_seq_model.put(8'(16 + k), 16'hA000 + 16'(k));
        u_prmc_seq_model.put(8'h29, 16'h5A5A);
        foreach (ptrs[k]) begin
            u_prmc_seq_model.put(8'h28, ptrs[k]);
            u_prmc_seq_model.put(8'h32, 16'h0000);
            run(mk(PRMC_OP_TABLE_SELECT_READ, 1'h1, 8'h10, 8'h28, 8'h32, 7'h0A, 5'h00));
            chk("rd_out", 16'(r), 16'(ptrs[k] >= 16'h000A));
            u_prmc_seq_model.get(8'h32, d);
            chk("rd_dst", d, ptrs[k] < 16'h000A ? 16'hA000 + ptrs[k] : 16'h0000);
            run(mk(PRMC_OP_TABLE_SELECT_WRITE, 1'h1, 8'h29, 8'h28, 8'h10, 7'h0A, 5'h00));
            chk("wr_out", 16'(r), 16'(ptrs[k] >= 16'h000A));
            u_prmc_seq_model.get(8'h10 + ptrs[k][7:0], d);
            chk("wr_dst", d, ptrs[k] < 16'h000A ? 16'h5A5A : 16'hA00A);
        end
        // a full 64-entry table reaches its last entry
        u_prmc_seq_model.put(8'h7F, 16'hC3C3);
        u_prmc_seq_model.put(8'h28, 16'h003F);
        run(mk(PRMC_OP_TABLE_SELECT_READ, 1'h1, 8'h40, 8'h28, 8'h32, 7'h40, 5'h00));
        chk("full_out", 16'(r), 16'h0000);
        u_prmc_seq_model.get(8'h32, d);
        chk("full_dst", d, 16'hC3C3);
        // a size of 65 is refused like a pointer over, though pointer 63 is below it
        u_prmc_seq_model.put(8'h32, 16'h0000);
        run(mk(PRMC_OP_TABLE_SELECT_READ, 1'h1, 8'h40, 8'h28, 8'h32, 7'h41, 5'h00));
        chk("size_out", 16'(r), 16'h0001);
        u_prmc_seq_model.get(8'h32, d);
        chk("size_dst", d, 16'h0000);
        $display("test table done");
    endtask : t_table
    task automatic t_compare;
        foreach (cmp_a[k]) begin
            u_prmc_seq_model.put(8'h3C, cmp_a[k]);
            u_prmc_seq_model.put(8'h3D, cmp_b[k]);
            run(mk(PRMC_OP_GT, 1'h1, 8'h3C, 8'h3D, 8'h00, 7'h00, 5'h00));
            chk("gt", 16'(r), 16'($signed(cmp_a[k]) > $signed(cmp_b[k])));
            ins = mk(PRMC_OP_GE, 1'h1, 8'h3C, 8'h3D, 8'h00, 7'h00, 5'h00);
            ins.b_const_sel = k[0];
            ins.b_const = cmp_b[k];
            // the constant path names operand A as register B, which would read as equal
            ins.b_addr = k[0] ? 8'h3C : 8'h3D;
            run(ins);
            chk("ge", 16'(r), 16'($signed(cmp_a[k]) >= $signed(cmp_b[k])));
        end
        $display("test compare done");
    endtask : t_compare
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1'h1;
        t_rotate();
        t_table();
        t_compare();
        summarize();
    end
endmodule : tb_prmc_unit
